/* File: rtl/tdcr_readout.sv */
`timescale 1ns/1ps
module tdcr_readout
    import tdcr_pkg::*;
#(
    parameter int W = WORD_W,
    parameter int DEPTH = MEM_DEPTH,
    parameter int LATENCY = ACCEPT_LATENCY,
    parameter int QDEPTH = DERAND_DEPTH
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [NUM_IN*W-1:0] inData,
    input wire logic [1:0] srcSel,
    input wire logic recordEn,
    input wire logic loadValid,
    input wire logic [4:0] loadChan,
    input wire logic [$clog2(DEPTH)-1:0] loadAddr,
    input wire logic [W-1:0] loadData,
    output logic loadReady,
    input wire logic bc0,
    input wire logic levelOneAccept,
    input wire logic [NUM_CH-1:0] readoutMask,
    input wire logic [2:0] winHalf,
    input wire logic clearStatus,
    output logic [NUM_OUT*W-1:0] trigOut,
    output logic bxTick,
    output logic [W-1:0] roData,
    output logic roValid,
    output logic roFirst,
    output logic roLast,
    input wire logic roReady,
    input wire logic [W-1:0] fwdData,
    input wire logic fwdValid,
    input wire logic fwdLast,
    output logic fwdReady,
    output logic syncLossStatus,
    output logic overflowStatus
);

    localparam int AW = $clog2(DEPTH);
    localparam int QW = $clog2(QDEPTH);
    localparam int DW = $clog2(BX_DIV);
    localparam int CHW = $clog2(NUM_CH);
    localparam int SW = 4;

    function automatic logic [W-1:0] maxW(input logic [W-1:0] a, input logic [W-1:0] b);
        maxW = (a > b) ? a : b;
    endfunction

    // Crossing divider and free-running capture address
    logic [DW-1:0] divCnt_q;
    logic [AW-1:0] bxAddr_q;
    logic [11:0] bxNum_q;

    assign bxTick = (divCnt_q == DW'(BX_DIV - 1));

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            divCnt_q <= '0;
        end
        else
        begin
            divCnt_q <= bxTick ? '0 : divCnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bxAddr_q <= '0;
        end
        else if (bxTick)
        begin
            bxAddr_q <= bxAddr_q + 1'b1;
        end
    end

    // Orbit counter; a marker off the expected crossing means alignment is lost
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bxNum_q <= '0;
            syncLossStatus <= 1'b0;
        end
        else
        begin
            if (bxTick)
            begin
                if (bc0 || bxNum_q == 12'(ORBIT_LEN - 1))
                begin
                    bxNum_q <= '0;
                end
                else
                begin
                    bxNum_q <= bxNum_q + 1'b1;
                end
            end
            if (bxTick && bc0 && bxNum_q != 12'(ORBIT_LEN - 1))
            begin
                syncLossStatus <= 1'b1;
            end
            else if (clearStatus)
            begin
                syncLossStatus <= 1'b0;
            end
        end
    end

    // Source selection and processing path
    logic [NUM_IN*W-1:0] injData;
    logic [NUM_IN*W-1:0] pathIn;
    logic [W-1:0] stageA [NUM_BANKS];
    logic [W-1:0] stageB;
    logic [NUM_CAP*W-1:0] capWord;
    logic liveSrc;

    assign liveSrc = (tdcr_src_t'(srcSel) == SRC_LIVE);
    assign pathIn = liveSrc ? inData : injData;

    always_comb
    begin
        stageB = '0;
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            stageA[b] = '0;
            for (int k = 0; k < BANK_SIZE; k++)
            begin
                stageA[b] = maxW(stageA[b], pathIn[(b*BANK_SIZE + k)*W +: W]);
            end
            stageB = maxW(stageB, stageA[b]);
        end
    end

    always_comb
    begin
        capWord = '0;
        for (int k = 0; k < NUM_OUT; k++)
        begin
            capWord[k*W +: W] = (k < NUM_BANKS) ? stageA[k % NUM_BANKS] : stageB;
        end
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            capWord[(MID_BASE + b)*W +: W] = stageA[b];
        end
        capWord[(MID_BASE + NUM_BANKS)*W +: W] = stageB;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            trigOut <= '0;
        end
        else if (bxTick)
        begin
            trigOut <= capWord[NUM_OUT*W-1:0];
        end
    end

    // Memory write control: recording beats a software load in the same cycle
    logic inRec;
    logic capRec;
    logic [NUM_IN-1:0] inWrEn;
    logic [NUM_IN*W-1:0] inWrData;
    logic [AW-1:0] inWrAddr;

    assign inRec = bxTick && recordEn && liveSrc;
    assign capRec = bxTick && recordEn;
    assign loadReady = !inRec;

    always_comb
    begin
        inWrEn = '0;
        inWrData = inData;
        inWrAddr = bxAddr_q;
        if (inRec)
        begin
            inWrEn = '1;
        end
        else if (loadValid && int'(loadChan) < NUM_IN)
        begin
            inWrEn[loadChan] = 1'b1;
            inWrAddr = loadAddr;
            inWrData = {NUM_IN{loadData}};
        end
    end

    // Readout sequencing state
    tdcr_state_t state_q;
    logic [AW-1:0] curAcc_q;
    logic [SW-1:0] step_q;
    logic [SW-1:0] win_q;
    logic [CHW-1:0] ch_q;
    logic [11:0] evCnt_q;
    logic [W-1:0] roData_q;
    logic fwdFirst_q;
    logic fwdLast_q;
    logic [AW-1:0] rdAddr;
    logic [W-1:0] inRdData;
    logic [W-1:0] capRdData;

    assign rdAddr = curAcc_q - AW'(win_q) + AW'(step_q);

    tdcr_cap_mem #(.N(NUM_IN), .W(W), .DEPTH(DEPTH)) inMem
    (
        .mclk(mclk),
        .rstn(rstn),
        .wrEn(inWrEn),
        .wrAddr(inWrAddr),
        .wrData(inWrData),
        .injAddr(bxAddr_q),
        .injData(injData),
        .rdChan(5'(ch_q)),
        .rdAddr(rdAddr),
        .rdData(inRdData)
    );

    tdcr_cap_mem #(.N(NUM_CAP), .W(W), .DEPTH(DEPTH)) capMem
    (
        .mclk(mclk),
        .rstn(rstn),
        .wrEn({NUM_CAP{capRec}}),
        .wrAddr(bxAddr_q),
        .wrData(capWord),
        .injAddr(bxAddr_q),
        .injData(),
        .rdChan(4'(ch_q - CHW'(NUM_IN))),
        .rdAddr(rdAddr),
        .rdData(capRdData)
    );

    // Derandomiser of accepted crossing addresses
    logic [AW-1:0] accQ [QDEPTH];
    logic [QW:0] qWr_q;
    logic [QW:0] qRd_q;
    logic qEmpty;
    logic qFull;
    logic qPop;

    assign qEmpty = (qWr_q == qRd_q);
    assign qFull = (qWr_q[QW-1:0] == qRd_q[QW-1:0]) && (qWr_q[QW] != qRd_q[QW]);
    assign qPop = (state_q == ST_IDLE) && !qEmpty;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            qWr_q <= '0;
            qRd_q <= '0;
        end
        else
        begin
            if (levelOneAccept && !qFull)
            begin
                qWr_q <= qWr_q + 1'b1;
            end
            if (qPop)
            begin
                qRd_q <= qRd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (levelOneAccept && !qFull)
        begin
            accQ[qWr_q[QW-1:0]] <= bxAddr_q - AW'(LATENCY);
        end
    end

    // Overflow is sticky; a new overflow wins over a clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            overflowStatus <= 1'b0;
        end
        else if (levelOneAccept && qFull)
        begin
            overflowStatus <= 1'b1;
        end
        else if (clearStatus)
        begin
            overflowStatus <= 1'b0;
        end
    end

    // Event block builder and merge of upstream blocks
    logic lastCh;
    logic lastStep;

    assign lastCh = (ch_q == CHW'(NUM_CH - 1));
    assign lastStep = (step_q == (win_q << 1));

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;
            curAcc_q <= '0;
            step_q <= '0;
            win_q <= '0;
            ch_q <= '0;
            evCnt_q <= '0;
            roData_q <= '0;
            fwdFirst_q <= 1'b0;
            fwdLast_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (!qEmpty)
                    begin
                        curAcc_q <= accQ[qRd_q[QW-1:0]];
                        // Window is frozen per block so a change cannot tear a block
                        win_q <= (winHalf > 3'(WIN_HALF_MAX)) ? SW'(WIN_HALF_MAX) : SW'(winHalf);
                        roData_q <= W'({HDR_TAG, evCnt_q});
                        state_q <= ST_HEAD;
                    end
                    else if (fwdValid)
                    begin
                        fwdFirst_q <= 1'b1;
                        state_q <= ST_FWD_LOAD;
                    end
                end
                ST_HEAD:
                begin
                    if (roReady)
                    begin
                        step_q <= '0;
                        ch_q <= '0;
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE:
                begin
                    if (readoutMask[ch_q])
                    begin
                        state_q <= ST_WAIT;
                    end
                    else if (lastCh)
                    begin
                        ch_q <= '0;
                        step_q <= step_q + 1'b1;
                        state_q <= lastStep ? ST_TAIL : ST_ISSUE;
                    end
                    else
                    begin
                        ch_q <= ch_q + 1'b1;
                    end
                end
                ST_WAIT:
                begin
                    roData_q <= (int'(ch_q) < NUM_IN) ? inRdData : capRdData;
                    state_q <= ST_DATA;
                end
                ST_DATA:
                begin
                    if (roReady)
                    begin
                        if (lastCh)
                        begin
                            ch_q <= '0;
                            step_q <= step_q + 1'b1;
                            state_q <= lastStep ? ST_TAIL : ST_ISSUE;
                        end
                        else
                        begin
                            ch_q <= ch_q + 1'b1;
                            state_q <= ST_ISSUE;
                        end
                    end
                end
                ST_TAIL:
                begin
                    if (roReady)
                    begin
                        evCnt_q <= evCnt_q + 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_FWD_LOAD:
                begin
                    if (fwdValid)
                    begin
                        roData_q <= fwdData;
                        fwdLast_q <= fwdLast;
                        state_q <= ST_FWD_SEND;
                    end
                end
                ST_FWD_SEND:
                begin
                    if (roReady)
                    begin
                        fwdFirst_q <= 1'b0;
                        state_q <= fwdLast_q ? ST_IDLE : ST_FWD_LOAD;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
            if (state_q == ST_DATA && roReady && lastCh && lastStep)
            begin
                roData_q <= W'({TAIL_TAG, evCnt_q});
            end
            else if (state_q == ST_ISSUE && !readoutMask[ch_q] && lastCh && lastStep)
            begin
                roData_q <= W'({TAIL_TAG, evCnt_q});
            end
        end
    end

    // Dedicated readout channel
    assign roData = roData_q;
    assign roValid = (state_q == ST_HEAD) || (state_q == ST_DATA) || (state_q == ST_TAIL) ||
                     (state_q == ST_FWD_SEND);
    assign roFirst = (state_q == ST_HEAD) || (state_q == ST_FWD_SEND && fwdFirst_q);
    assign roLast = (state_q == ST_TAIL) || (state_q == ST_FWD_SEND && fwdLast_q);
    assign fwdReady = (state_q == ST_FWD_LOAD);

endmodule // tdcr_readout

/* File: shared/tdcr_pkg.sv */
package tdcr_pkg;

    // Timing
    localparam int CLK_PERIOD_PS = 10000;
    localparam int BX_PERIOD_NS = 25;
    // Longest whole number of clocks inside one crossing, never below two
    localparam int BX_DIV_RAW = (BX_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int BX_DIV = (BX_DIV_RAW < 2) ? 2 : BX_DIV_RAW;

    // Board organisation
    localparam int NUM_IN = 18;
    localparam int BANK_SIZE = 6;
    localparam int NUM_BANKS = NUM_IN / BANK_SIZE;
    localparam int NUM_OUT = 6;
    localparam int NUM_MID = NUM_BANKS + 1;
    localparam int NUM_CAP = NUM_OUT + NUM_MID;
    localparam int NUM_CH = NUM_IN + NUM_CAP;
    localparam int WORD_W = 16;

    // Capture and readout
    localparam int MEM_DEPTH = 256;
    localparam int ACCEPT_LATENCY = 64;
    localparam int WIN_HALF_MAX = 4;
    localparam int DERAND_DEPTH = 8;
    localparam int ORBIT_LEN = 4000;

    // Output channel index of the first intermediate result inside the output memory
    localparam int MID_BASE = NUM_OUT;

    // Block framing
    localparam logic [3:0] HDR_TAG = 4'hA;
    localparam logic [3:0] TAIL_TAG = 4'hE;

    typedef enum logic [1:0]
    {
        SRC_LIVE,
        SRC_CAPTURED,
        SRC_SIMULATED
    } tdcr_src_t;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_HEAD,
        ST_ISSUE,
        ST_WAIT,
        ST_DATA,
        ST_TAIL,
        ST_FWD_LOAD,
        ST_FWD_SEND
    } tdcr_state_t;

endpackage

/* File: rtl/tdcr_cap_mem.sv */
`timescale 1ns/1ps
module tdcr_cap_mem
    import tdcr_pkg::*;
#(
    parameter int N = NUM_IN,
    parameter int W = WORD_W,
    parameter int DEPTH = MEM_DEPTH,
    parameter int AW = $clog2(DEPTH),
    parameter int CW = $clog2(N)
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [N-1:0] wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [N*W-1:0] wrData,
    input wire logic [AW-1:0] injAddr,
    output logic [N*W-1:0] injData,
    input wire logic [CW-1:0] rdChan,
    input wire logic [AW-1:0] rdAddr,
    output logic [W-1:0] rdData
);

    // One deep ring per channel, flattened so one array serves all channels
    logic [W-1:0] mem [N*DEPTH];

    always_ff @(posedge mclk)
    begin
        for (int c = 0; c < N; c++)
        begin
            if (wrEn[c])
            begin
                mem[c * DEPTH + int'(wrAddr)] <= wrData[c*W +: W];
            end
        end
    end

    // All channels at the crossing address, for injection into the path
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            injData <= '0;
        end
        else
        begin
            for (int c = 0; c < N; c++)
            begin
                injData[c*W +: W] <= mem[c * DEPTH + int'(injAddr)];
            end
        end
    end

    // Single channel port for readout
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdData <= '0;
        end
        else if (int'(rdChan) < N)
        begin
            rdData <= mem[int'(rdChan) * DEPTH + int'(rdAddr)];
        end
    end

endmodule // tdcr_cap_mem

/* File: tb/tdcr_checker.sv */
`timescale 1ns/1ps
module tdcr_checker
    import tdcr_pkg::*;
#(
    parameter int W = WORD_W
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic bxTick,
    input wire logic bc0,
    input wire logic levelOneAccept,
    input wire logic clearStatus,
    input wire logic recordEn,
    input wire logic [1:0] srcSel,
    input wire logic loadReady,
    input wire logic [NUM_OUT*W-1:0] trigOut,
    input wire logic [W-1:0] roData,
    input wire logic roValid,
    input wire logic roFirst,
    input wire logic roLast,
    input wire logic roReady,
    input wire logic [W-1:0] fwdData,
    input wire logic fwdValid,
    input wire logic fwdReady,
    input wire logic syncLossStatus,
    input wire logic overflowStatus
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    tick_period_a: assert property (bxTick |=> !bxTick ##1 bxTick)
        else $error("crossing strobe spacing wrong");
    sync_cause_a: assert property ($rose(syncLossStatus) |-> $past(bxTick && bc0))
        else $error("sync loss set without orbit marker");
    sync_hold_a: assert property (syncLossStatus && !clearStatus |=> syncLossStatus)
        else $error("sync loss dropped without clear");
    sync_clear_a: assert property (clearStatus && !(bxTick && bc0) |=> !syncLossStatus)
        else $error("sync loss not cleared");
    ovf_cause_a: assert property ($rose(overflowStatus) |-> $past(levelOneAccept))
        else $error("overflow set without accept");
    ovf_hold_a: assert property (overflowStatus && !clearStatus |=> overflowStatus)
        else $error("overflow dropped without clear");
    ovf_clear_a: assert property (clearStatus && !levelOneAccept |=> !overflowStatus)
        else $error("overflow not cleared");
    ro_hold_a: assert property (roValid && !roReady |=> roValid && $stable(roData) && $stable({roFirst, roLast}))
        else $error("readout word changed while stalled");
    fwd_pass_a: assert property (fwdValid && fwdReady |=> roValid && roData == $past(fwdData))
        else $error("forwarded word not passed on");
    load_gate_a: assert property (loadReady != (bxTick && recordEn && srcSel == 2'h0))
        else $error("load ready wrong");
    out_hold_a: assert property (!bxTick |=> $stable(trigOut))
        else $error("trigger output moved between crossings");
endmodule // tdcr_checker

bind tdcr_readout tdcr_checker #(.W(W)) u_tdcr_checker (
    .mclk(mclk), .rstn(rstn), .bxTick(bxTick), .bc0(bc0), .levelOneAccept(levelOneAccept),
    .clearStatus(clearStatus), .recordEn(recordEn), .srcSel(srcSel), .loadReady(loadReady),
    .trigOut(trigOut), .roData(roData), .roValid(roValid), .roFirst(roFirst), .roLast(roLast),
    .roReady(roReady), .fwdData(fwdData), .fwdValid(fwdValid), .fwdReady(fwdReady),
    .syncLossStatus(syncLossStatus), .overflowStatus(overflowStatus)
);

/* File: tb/tdcr_ro_sink.sv */
`timescale 1ns/1ps
module tdcr_ro_sink
    import tdcr_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [WORD_W-1:0] roData,
    input wire logic roValid,
    input wire logic roFirst,
    input wire logic roLast,
    input wire logic [1:0] stallMode,
    output logic roReady
);
    logic [WORD_W-1:0] got[$];
    logic [1:0] flg[$];
    logic [1:0] phase_q;

    // Mode 0 always ready, 1 one cycle in three, 2 held off to back up the queue
    assign roReady = (stallMode == 2'h0) || (stallMode == 2'h1 && phase_q == 2'h2);

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q <= 2'h0;
        end
        else
        begin
            phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
            if (roValid && roReady)
            begin
                got.push_back(roData);
                flg.push_back({roFirst, roLast});
            end
        end
    end
endmodule // tdcr_ro_sink

/* File: tb/tdcr_readout_tb.sv */
`timescale 1ns/1ps
module tdcr_readout_tb
    import tdcr_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [NUM_IN*WORD_W-1:0] inData = '0;
    logic [1:0] srcSel = 2'h0;
    logic [1:0] stallMode = 2'h0;
    logic recordEn = 1'b0;
    logic loadValid = 1'b0;
    logic [4:0] loadChan = 5'h00;
    logic [7:0] loadAddr = 8'h00;
    logic [WORD_W-1:0] loadData = 16'h0000;
    logic [WORD_W-1:0] fwdData = 16'h0000;
    logic bc0 = 1'b0;
    logic levelOneAccept = 1'b0;
    logic clearStatus = 1'b0;
    logic fwdValid = 1'b0;
    logic fwdLast = 1'b0;
    logic [NUM_CH-1:0] readoutMask = '0;
    logic [2:0] winHalf = 3'h0;
    logic loadReady, bxTick, roValid, roFirst, roLast, roReady, fwdReady, syncLossStatus, overflowStatus;
    logic [NUM_OUT*WORD_W-1:0] trigOut;
    logic [WORD_W-1:0] roData;
    logic [11:0] evtNum = 12'h000;
    int nMismatch = 0;
    int cmpCount = 0;
    int cycles = 0;

    always #5 mclk = ~mclk;

    tdcr_readout u_tdcr_readout (
        .mclk(mclk), .rstn(rstn), .inData(inData), .srcSel(srcSel), .recordEn(recordEn),
        .loadValid(loadValid), .loadChan(loadChan), .loadAddr(loadAddr), .loadData(loadData),
        .loadReady(loadReady), .bc0(bc0), .levelOneAccept(levelOneAccept), .readoutMask(readoutMask),
        .winHalf(winHalf), .clearStatus(clearStatus), .trigOut(trigOut), .bxTick(bxTick),
        .roData(roData), .roValid(roValid), .roFirst(roFirst), .roLast(roLast), .roReady(roReady),
        .fwdData(fwdData), .fwdValid(fwdValid), .fwdLast(fwdLast), .fwdReady(fwdReady),
        .syncLossStatus(syncLossStatus), .overflowStatus(overflowStatus)
    );

    tdcr_ro_sink u_tdcr_ro_sink (
        .mclk(mclk), .rstn(rstn), .roData(roData), .roValid(roValid), .roFirst(roFirst),
        .roLast(roLast), .stallMode(stallMode), .roReady(roReady)
    );

    task automatic test_done();
        $display("Mismatches %0d, comparisons %0d", nMismatch, cmpCount);
        if (nMismatch == 0 && cmpCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            nMismatch++;
            test_done();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string what);
        cmpCount++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Captured value of each channel while every input carries its own index
    function automatic logic [WORD_W-1:0] chVal(input int c);
        if (c < NUM_IN)
            return 16'h1000 + WORD_W'(c);
        if (c == NUM_CH - 1 || (c >= NUM_IN + NUM_BANKS && c < NUM_IN + NUM_OUT))
            return 16'h1011;
        return 16'h1005 + WORD_W'(6 * ((c - NUM_IN) % NUM_BANKS));
    endfunction

    task automatic t_reset();
        #1;
        chk(16'({roValid, bxTick, syncLossStatus, overflowStatus, fwdReady}), 16'h0000, "reset flags");
        chk(16'(loadReady), 16'h0001, "reset load ready");
        chk(trigOut[15:0], 16'h0000, "reset output");
    endtask

    task automatic t_record();
        srcSel <= 2'h0;
        recordEn <= 1'b1;
        for (int c = 0; c < NUM_IN; c++)
            inData[c*WORD_W +: WORD_W] <= chVal(c);
        step(600);
        #1;
        chk(trigOut[15:0], 16'h1005, "bank 0 max");
        chk(trigOut[31:16], 16'h100B, "bank 1 max");
        chk(trigOut[47:32], 16'h1011, "bank 2 max");
        chk(trigOut[63:48], 16'h1011, "second stage");
        for (int i = 0; i < 8; i++)
        begin
            step(1);
            #1;
            chk(16'(loadReady), 16'(!bxTick), "load ready gate");
        end
    endtask

    task automatic t_block(input logic [NUM_CH-1:0] mask, input int win, input logic [1:0] stall);
        int n;
        int k;
        int steps;
        steps = 2 * ((win > 4) ? 4 : win) + 1;
        n = steps * $countones(mask) + 2;
        k = 1;
        u_tdcr_ro_sink.got.delete();
        u_tdcr_ro_sink.flg.delete();
        readoutMask <= mask;
        winHalf <= 3'(win);
        stallMode <= stall;
        levelOneAccept <= 1'b1;
        step(1);
        levelOneAccept <= 1'b0;
        for (int i = 0; i < 4000 && u_tdcr_ro_sink.got.size() < n; i++)
            step(1);
        step(20);
        chk(16'(u_tdcr_ro_sink.got.size()), 16'(n), "block size");
        if (u_tdcr_ro_sink.got.size() == n)
        begin
            chk(u_tdcr_ro_sink.got[0], {4'hA, evtNum}, "header");
            chk(u_tdcr_ro_sink.got[n-1], {4'hE, evtNum}, "tail");
            chk(16'({u_tdcr_ro_sink.flg[0], u_tdcr_ro_sink.flg[n-1]}), 16'h0009, "framing");
            for (int s = 0; s < steps; s++)
                for (int c = 0; c < NUM_CH; c++)
                    if (mask[c])
                    begin
                        chk(u_tdcr_ro_sink.got[k], chVal(c), "data word");
                        k++;
                    end
        end
        evtNum++;
    endtask

    task automatic t_overflow();
        u_tdcr_ro_sink.got.delete();
        readoutMask <= 28'h000_0001;
        winHalf <= 3'h0;
        stallMode <= 2'h2;
        levelOneAccept <= 1'b1;
        step(10);
        levelOneAccept <= 1'b0;
        step(1);
        #1;
        chk(16'(overflowStatus), 16'h0001, "overflow set");
        step(3);
        #1;
        chk(16'(overflowStatus), 16'h0001, "overflow sticky");
        clearStatus <= 1'b1;
        step(1);
        clearStatus <= 1'b0;
        step(1);
        #1;
        chk(16'(overflowStatus), 16'h0000, "overflow cleared");
        stallMode <= 2'h0;
        step(1500);
        chk(16'(u_tdcr_ro_sink.got.size()), 16'h001B, "blocks kept");
        evtNum += 12'h009;
    endtask

    task automatic t_inject();
        srcSel <= 2'h2;
        step(1);
        // Simulated mode never records inputs, so every edge takes a word
        loadValid <= 1'b1;
        for (int a = 0; a < 512; a++)
        begin
            loadChan <= (a < 256) ? 5'h00 : 5'h06;
            loadAddr <= 8'(a);
            loadData <= (a < 256) ? 16'hFFFF : 16'h2000;
            step(1);
        end
        loadValid <= 1'b0;
        step(20);
        #1;
        chk(trigOut[15:0], 16'hFFFF, "simulated bank 0");
        chk(trigOut[31:16], 16'h2000, "simulated bank 1");
        srcSel <= 2'h1;
        step(20);
        #1;
        chk(trigOut[15:0], 16'hFFFF, "replay bank 0");
        srcSel <= 2'h0;
        step(20);
        #1;
        chk(trigOut[15:0], 16'h1005, "live bank 0");
    endtask

    task automatic t_forward();
        u_tdcr_ro_sink.got.delete();
        u_tdcr_ro_sink.flg.delete();
        stallMode <= 2'h1;
        for (int i = 0; i < 3; i++)
        begin
            fwdData <= 16'hC000 + 16'(i);
            fwdLast <= (i == 2);
            fwdValid <= 1'b1;
            @(posedge mclk iff fwdReady === 1'b1);
        end
        fwdValid <= 1'b0;
        fwdLast <= 1'b0;
        step(100);
        chk(16'(u_tdcr_ro_sink.got.size()), 16'h0003, "forward size");
        if (u_tdcr_ro_sink.got.size() == 3)
        begin
            chk(u_tdcr_ro_sink.got[1], 16'hC001, "forward data");
            chk(16'({u_tdcr_ro_sink.flg[0], u_tdcr_ro_sink.flg[2]}), 16'h0009, "forward framing");
        end
    endtask

    // Each marker spans two edges, so exactly one crossing sees it
    task automatic t_sync();
        bc0 <= 1'b1;
        step(2);
        bc0 <= 1'b0;
        step(2);
        clearStatus <= 1'b1;
        step(1);
        clearStatus <= 1'b0;
        step(7995);
        bc0 <= 1'b1;
        step(2);
        bc0 <= 1'b0;
        step(2);
        #1;
        chk(16'(syncLossStatus), 16'h0000, "orbit in step");
        step(50);
        bc0 <= 1'b1;
        step(2);
        bc0 <= 1'b0;
        step(2);
        #1;
        chk(16'(syncLossStatus), 16'h0001, "orbit out of step");
    endtask

    initial
    begin
        step(12);
        t_reset();
        rstn <= 1'b1;
        t_record();
        t_block(28'hA04_0021, 1, 2'h1);
        t_block(28'h002_0000, 7, 2'h0);
        t_overflow();
        t_block(28'h000_0001, 0, 2'h0);
        t_inject();
        t_forward();
        t_sync();
        test_done();
    end
endmodule // tdcr_readout_tb
